// file: hw/rpm_top.sv
// regulator power mode select: control register, wishbone slave and mode decision
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module rpm_top (
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        ce_i,
    input  wire logic                        cyc_i,
    input  wire logic                        stb_i,
    input  wire logic                        we_i,
    input  wire logic [rpm_pkg::ADR_W-1:0]   adr_i,
    input  wire logic [rpm_pkg::DAT_W/8-1:0] sel_i,
    input  wire logic [rpm_pkg::DAT_W-1:0]   dat_i,
    output logic      [rpm_pkg::DAT_W-1:0]   dat_o,
    output logic                             ack_o,
    input  wire rpm_pkg::rpm_status_t        status_i,
    input  wire logic                        supply_low_i,
    output rpm_pkg::rpm_mode_t               mode_o
);

    rpm_pkg::rpm_state_t  q;
    rpm_pkg::rpm_state_t  d;
    rpm_pkg::rpm_wb_req_t req;
    logic                 hit_ctl;
    logic                 hit_stat;
    logic                 take;
    logic                 force_low;

    // bundle the bus request
    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i, sel: sel_i, dat: dat_i};

    // address decode and acceptance of a new request
    assign hit_ctl  = (req.adr == rpm_pkg::CTRL_OFS);
    assign hit_stat = (req.adr == rpm_pkg::STAT_OFS);
    assign take     = req.cyc && req.stb && !q.ack;

    // activity that keeps the regulator out of power-save
    assign force_low = status_i.brownout_en || status_i.hfosc_active
                    || status_i.self_write || status_i.adc_busy;

    // next state
    always_comb
    begin
        d = q;
        // bus answers one cycle after the request, drops the next
        d.ack = take;
        if (take)
        begin
            d.rdat = '0; // unmapped and unimplemented bits read zero
            if (hit_ctl)
            begin
                d.rdat[rpm_pkg::SEL_BIT] = q.ctl_sel;
                d.rdat[rpm_pkg::RSV_BIT] = q.ctl_rsv;
            end
            else if (hit_stat)
            begin
                d.rdat = (rpm_pkg::REG_W)'(q.mode);
            end
            // only lane 0 holds the register; bits 7 to 2 ignore writes
            if (req.we && hit_ctl && req.sel[0])
            begin
                d.ctl_sel = req.dat[rpm_pkg::SEL_BIT];
                d.ctl_rsv = req.dat[rpm_pkg::RSV_BIT];
            end
        end
        // supply-low comparator crosses in by three flops
        d.sync = {q.sync[1:0], supply_low_i};
        if (q.sync[1] == q.sync[2])
        begin
            d.sup_low = q.sync[2];
        end
        // mode decision, re-evaluated every cycle
        if (q.sup_low)
        begin
            d.mode = rpm_pkg::MODE_TRACK;
        end
        else if (!status_i.sleep)
        begin
            if (status_i.bias == rpm_pkg::BIAS_LOW)
            begin
                d.mode = rpm_pkg::MODE_LOW;
            end
            else
            begin
                d.mode = rpm_pkg::MODE_HIGH;
            end
        end
        else if (!q.ctl_sel)
        begin
            d.mode = rpm_pkg::MODE_LOW;
        end
        else if (force_low || status_i.periph_active)
        begin
            d.mode = rpm_pkg::MODE_LOW;
        end
        else
        begin
            d.mode = rpm_pkg::MODE_SAVE;
        end
    end

    // state register, frozen while the clock enable is low unless reset is high
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q.ack     <= 1'b0;
            q.rdat    <= '0;
            q.ctl_sel <= rpm_pkg::SEL_RST;
            q.ctl_rsv <= rpm_pkg::RSV_RST;
            q.mode    <= rpm_pkg::MODE_HIGH;
            q.sync    <= rpm_pkg::SYNC_RST;
            q.sup_low <= 1'b0;
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign ack_o  = q.ack;
    assign dat_o  = {{(rpm_pkg::DAT_W-rpm_pkg::REG_W){1'b0}}, q.rdat};
    assign mode_o = q.mode;

    // checks on the mode decision
    a_awake_high: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !q.sup_low && !status_i.sleep && status_i.bias != rpm_pkg::BIAS_LOW
        |=> mode_o == rpm_pkg::MODE_HIGH)
        else $error("awake fast clock did not give high mode");

    a_awake_low: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !q.sup_low && !status_i.sleep && status_i.bias == rpm_pkg::BIAS_LOW
        |=> mode_o == rpm_pkg::MODE_LOW)
        else $error("awake slow clock did not give low mode");

    a_sleep_low: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !q.sup_low && status_i.sleep && !q.ctl_sel
        |=> mode_o == rpm_pkg::MODE_LOW)
        else $error("sleep with select clear did not give low mode");

    a_sleep_save: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !q.sup_low && status_i.sleep && q.ctl_sel && !force_low
        && !status_i.periph_active
        |=> mode_o == rpm_pkg::MODE_SAVE)
        else $error("quiet sleep did not give power-save mode");

    a_save_override: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !q.sup_low && status_i.sleep
        && (status_i.brownout_en || status_i.hfosc_active
            || status_i.self_write || status_i.adc_busy)
        |=> mode_o == rpm_pkg::MODE_LOW)
        else $error("active condition did not force low mode");

    a_track_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && supply_low_i ##1 (ce_i && supply_low_i) [*3] ##1 ce_i
        |=> mode_o == rpm_pkg::MODE_TRACK)
        else $error("held supply-low did not reach tracking mode");

    // checks on the register, the frozen mode and the acknowledge pulse
    a_unimpl_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |-> dat_o[rpm_pkg::DAT_W-1:rpm_pkg::SEL_BIT+1] == '0)
        else $error("unimplemented bits read nonzero");

    a_reset_vals: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> q.ctl_sel == rpm_pkg::SEL_RST && q.ctl_rsv == rpm_pkg::RSV_RST)
        else $error("control register reset value wrong");

    a_ctl_write: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && take && req.we && hit_ctl && req.sel[0]
        |=> q.ctl_sel == $past(dat_i[rpm_pkg::SEL_BIT])
            && q.ctl_rsv == $past(dat_i[rpm_pkg::RSV_BIT]))
        else $error("control write not stored");

    a_mode_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i |=> $stable(mode_o))
        else $error("mode changed while clock enable low");

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && ce_i |=> !ack_o)
        else $error("acknowledge held for two cycles");

    // checks on the bus handshake, the read data, the reset outputs and the frozen state
    a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && cyc_i && stb_i && !ack_o
        |=> ack_o)
        else $error("accepted request was not acknowledged");

    a_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !(cyc_i && stb_i)
        |=> !ack_o)
        else $error("acknowledge without a request");

    a_dat_steady: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !take
        |=> $stable(dat_o))
        else $error("read data moved without an access");

    a_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && take && !hit_ctl && !hit_stat
        |=> dat_o == '0)
        else $error("unmapped read returned nonzero data");

    a_reset_outputs: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i
        |=> !ack_o && dat_o == '0 && mode_o == rpm_pkg::MODE_HIGH)
        else $error("outputs not at reset values after reset");

    a_state_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
        !ce_i
        |=> $stable(q))
        else $error("state changed while clock enable low");

    // further checks on the register
    a_ctl_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && take && hit_ctl
        |=> dat_o[rpm_pkg::SEL_BIT] == $past(q.ctl_sel)
            && dat_o[rpm_pkg::RSV_BIT] == $past(q.ctl_rsv))
        else $error("control read did not return the stored bits");

    a_stat_read: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && take && hit_stat
        |=> dat_o == (rpm_pkg::DAT_W)'($past(mode_o)))
        else $error("status read did not return the live mode");

    a_write_masked: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && take && req.we && !(hit_ctl && req.sel[0])
        |=> $stable(q.ctl_sel) && $stable(q.ctl_rsv))
        else $error("ignored write changed the control register");

    a_ctl_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !take
        |=> $stable(q.ctl_sel) && $stable(q.ctl_rsv))
        else $error("control register changed without a write");

    // checks on the supply-low path
    a_sync_shift: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i
        |=> q.sync == {$past(q.sync[1:0]), $past(supply_low_i)})
        else $error("supply-low synchroniser did not shift");

    a_filter_agree: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && q.sync[1] == q.sync[2]
        |=> q.sup_low == $past(q.sync[2]))
        else $error("agreeing samples did not update the filter");

    a_filter_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && q.sync[1] != q.sync[2]
        |=> $stable(q.sup_low))
        else $error("disagreeing samples moved the filter");

    a_track_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && q.sup_low
        |=> mode_o == rpm_pkg::MODE_TRACK)
        else $error("filtered supply-low did not give tracking mode");

    a_track_only_low: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !q.sup_low
        |=> mode_o != rpm_pkg::MODE_TRACK)
        else $error("tracking mode without supply-low");

    a_track_exit: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !supply_low_i ##1 (ce_i && !supply_low_i) [*3] ##1 ce_i
        |=> mode_o != rpm_pkg::MODE_TRACK)
        else $error("restored supply did not leave tracking mode");

    // further checks on the mode decision
    a_wake_no_save: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !status_i.sleep
        |=> mode_o != rpm_pkg::MODE_SAVE)
        else $error("power-save mode while awake");

    a_medium_high: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !q.sup_low && !status_i.sleep && status_i.bias == rpm_pkg::BIAS_MEDIUM
        |=> mode_o == rpm_pkg::MODE_HIGH)
        else $error("medium bias did not give high mode");

    a_sleep_no_high: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && status_i.sleep
        |=> mode_o != rpm_pkg::MODE_HIGH)
        else $error("high mode while asleep");

    a_periph_low: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !q.sup_low && status_i.sleep && status_i.periph_active
        |=> mode_o == rpm_pkg::MODE_LOW)
        else $error("active peripheral did not keep low mode in sleep");

    a_save_needs_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && !q.ctl_sel
        |=> mode_o != rpm_pkg::MODE_SAVE)
        else $error("power-save mode with select clear");

endmodule : rpm_top

`default_nettype wire

// file: include/rpm_pkg.sv
// package: register map, field layout, modes and carrier types of the regulator mode select
package rpm_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] CTRL_OFS = 8'h00; // regulator_power_control
    localparam logic [7:0] STAT_OFS = 8'h04; // live regulator mode
    localparam int unsigned ADR_W = 8;

    // control register field layout
    localparam int unsigned SEL_BIT = 1; // sleep_regulator_select
    localparam int unsigned RSV_BIT = 0; // reserved, keep set
    localparam logic SEL_RST = 1'b0;
    localparam logic RSV_RST = 1'b1;

    // width of the bus data word and of the implemented register
    localparam int unsigned DAT_W = 32;
    localparam int unsigned REG_W = 8;

    // oscillator bias class of the running clock
    typedef enum logic [1:0] {
        BIAS_HIGH   = 2'h0, // external clock or 16 MHz internal oscillator
        BIAS_MEDIUM = 2'h1, // 1 to 8 MHz internal oscillator
        BIAS_LOW    = 2'h3  // 31 kHz to 500 kHz internal oscillator
    } rpm_bias_t;

    // internal_regulator power mode, gray along high-low-save
    typedef enum logic [1:0] {
        MODE_HIGH  = 2'h0,
        MODE_LOW   = 2'h1,
        MODE_SAVE  = 2'h3,
        MODE_TRACK = 2'h2
    } rpm_mode_t;

    // power and clock status from the rest of the system
    typedef struct packed {
        logic      sleep;         // core is asleep
        rpm_bias_t bias;          // bias class of the running clock
        logic      brownout_en;   // brownout_detect enabled
        logic      hfosc_active;  // high_freq_internal_osc serves a peripheral
        logic      periph_active; // some other peripheral is running
        logic      self_write;    // self-write in progress
        logic      adc_busy;      // conversion in progress
    } rpm_status_t;

    // classic wishbone request
    typedef struct packed {
        logic                 cyc;
        logic                 stb;
        logic                 we;
        logic [ADR_W-1:0]     adr;
        logic [DAT_W/8-1:0]   sel;
        logic [DAT_W-1:0]     dat;
    } rpm_wb_req_t;

    // whole state of the block
    typedef struct packed {
        logic             ack;      // bus acknowledge
        logic [REG_W-1:0] rdat;     // captured read data
        logic             ctl_sel;  // sleep_regulator_select
        logic             ctl_rsv;  // reserved bit
        rpm_mode_t        mode;     // selected regulator mode
        logic [2:0]       sync;     // supply-low synchroniser
        logic             sup_low;  // filtered supply-low level
    } rpm_state_t;

    localparam logic [2:0] SYNC_RST = 3'h0;

endpackage : rpm_pkg

// file: verification/rpm_tb.sv
// testbench: register access and regulator mode selection of rpm_top
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic                 cyc_i = 1'b0;
    logic                 stb_i = 1'b0;
    logic                 we_i = 1'b0;
    logic [7:0]           adr_i = 8'h00;
    logic [3:0]           sel_i = 4'h0;
    logic [31:0]          dat_i = 32'h0;
    logic [31:0]          dat_o;
    logic                 ack_o;
    rpm_pkg::rpm_status_t status_i = '0;
    logic                 supply_low_i = 1'b0;
    rpm_pkg::rpm_mode_t   mode_o;
    int                   err_total = 0;
    int                   checks = 0;
    int                   cycles = 0;
    logic [31:0]          rd;
    logic                 ce_i = 1'b1;
    logic [3:0]           lane = 4'h1;

    rpm_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .status_i(status_i), .supply_low_i(supply_low_i), .mode_o(mode_o));

    // free-running 100 MHz clock
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    // hang guard
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t data %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_mode(input rpm_pkg::rpm_mode_t exp);
        checks++;
        if (mode_o !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t mode %h expected %h", $time, mode_o, exp);
        end
    endtask : chk_mode

    // one classic wishbone cycle, entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= lane;
        dat_i <= d;
        @(posedge clk_i);
        // only ack_o going high or the hang guard ends this wait
        while (ack_o !== 1'b1)
        begin
            @(posedge clk_i);
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, ack_o}, 32'h0); // acknowledge lasts one cycle
    endtask : wb

    // apply status, let it land, compare the mode
    task automatic md(input logic [7:0] s, input rpm_pkg::rpm_mode_t e);
        status_i <= rpm_pkg::rpm_status_t'(s);
        repeat (2) @(posedge clk_i);
        chk_mode(e);
    endtask : md

    // main sequence
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, rpm_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h1);
        wb(1'b1, rpm_pkg::CTRL_OFS, 32'hffff_ffff);
        wb(1'b0, rpm_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h3);
        wb(1'b1, rpm_pkg::CTRL_OFS, 32'h1);
        wb(1'b0, rpm_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h1);
        // writes without lane 0 and writes to status are ignored
        lane = 4'he;
        wb(1'b1, rpm_pkg::CTRL_OFS, 32'h3);
        lane = 4'h1;
        wb(1'b1, rpm_pkg::STAT_OFS, 32'h3);
        wb(1'b0, rpm_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h1);
        wb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        md(8'h00, rpm_pkg::MODE_HIGH);
        md(8'h20, rpm_pkg::MODE_HIGH);
        md(8'h60, rpm_pkg::MODE_LOW);
        md(8'h10, rpm_pkg::MODE_HIGH);
        md(8'h80, rpm_pkg::MODE_LOW);
        md(8'he0, rpm_pkg::MODE_LOW);
        wb(1'b1, rpm_pkg::CTRL_OFS, 32'h3);
        md(8'h80, rpm_pkg::MODE_SAVE);
        md(8'ha0, rpm_pkg::MODE_SAVE);
        for (int i = 0; i < 5; i++)
            md(8'h80 | (8'h01 << i), rpm_pkg::MODE_LOW);
        md(8'h80, rpm_pkg::MODE_SAVE);
        wb(1'b0, rpm_pkg::STAT_OFS, 32'h0);
        chk(rd, 32'h3);
        // clock enable low freezes the mode, then it catches up
        ce_i <= 1'b0;
        status_i <= '0;
        repeat (3) @(posedge clk_i);
        chk_mode(rpm_pkg::MODE_SAVE);
        ce_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk_mode(rpm_pkg::MODE_HIGH);
        supply_low_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk_mode(rpm_pkg::MODE_TRACK);
        md(8'h00, rpm_pkg::MODE_TRACK);
        supply_low_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk_mode(rpm_pkg::MODE_HIGH);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, rpm_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h1);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
